/* design/bcrd_pkg.sv */
// Constants, field layout and types of the block-transfer command and raster-op decoder
// Summary of operation
// - Read transfer halts fetching on full result FIFO, resumes below 14 entries
// - Read transfer never tops the FIFO up; it only pauses while host drains
// - Command register: raster-op code in bits 19-16, operation selector in 3-0
// - Raster-op code bits 2-0 give color-expansion start bit within source byte
// - Result bit equals code bit indexed by two times source plus destination
// - Pattern fill uses same sixteen functions, pattern pixel replacing source pixel
// - Selector 0-3: write, read, positive move, negative move; above 1100 reserved
// - Selector 4-12: transparent/pattern/expansion variants, then solid fill
// - Source start address is 21 bits in bits 20-0 of its register
// - Host-sourced pixels use only address bit 0, byte alignment in 16-bit word
// - At 8 bpp: base bits 20:6, line bits 5:3, pixel bits 2:0
// - At 16 bpp: base bits 20:7, line bits 6:4, pixel bits 3:0
// - Color-format bit: clear means 8 bpp, set means 16 bpp
// - Writing one to write-only enable starts; clearing it mid-operation is ignored
package bcrd_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int PIX_W  = 16;
    localparam int SRC_W  = 21;

    localparam logic [16:0] OFF_CTRL = 17'h08000;
    localparam logic [16:0] OFF_STAT = 17'h08004;
    localparam logic [16:0] OFF_CMD  = 17'h08008;
    localparam logic [16:0] OFF_SRC  = 17'h0800C;
    localparam logic [16:0] OFF_DATA = 17'h10000;

    localparam logic [31:0] CMD_RST  = 32'h00000000;
    localparam logic [31:0] SRC_RST  = 32'h00000000;

    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_FMT_BIT = 18;
    localparam int CMD_ROP_LSB  = 16;
    localparam int CMD_OP_LSB   = 0;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_FULL    = 4;
    localparam int STAT_HALF    = 5;
    localparam int STAT_NEMPTY  = 6;
    localparam int STAT_FREE_LSB = 16;
    localparam int STAT_USED_LSB = 24;

    localparam int P8_BASE_LSB  = 6;
    localparam int P8_LINE_LSB  = 3;
    localparam int P16_BASE_LSB = 7;
    localparam int P16_LINE_LSB = 4;

    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_RESUME = 14;

    localparam logic [3:0] OPC_WRITE_ROP  = 4'h0;
    localparam logic [3:0] OPC_READ       = 4'h1;
    localparam logic [3:0] OPC_MOVE_POS   = 4'h2;
    localparam logic [3:0] OPC_MOVE_NEG   = 4'h3;
    localparam logic [3:0] OPC_TWRITE     = 4'h4;
    localparam logic [3:0] OPC_TMOVE_POS  = 4'h5;
    localparam logic [3:0] OPC_PAT_ROP    = 4'h6;
    localparam logic [3:0] OPC_PAT_TRANS  = 4'h7;
    localparam logic [3:0] OPC_CEXP       = 4'h8;
    localparam logic [3:0] OPC_CEXP_T     = 4'h9;
    localparam logic [3:0] OPC_MOVE_CEXP  = 4'hA;
    localparam logic [3:0] OPC_MOVE_CEXPT = 4'hB;
    localparam logic [3:0] OPC_SOLID      = 4'hC;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_PAUSE
    } bcrd_fetch_e;
endpackage

/* design/bcrd_fifo_if.sv */
// Valid/ready carrier between the fetch path, the result FIFO and the host drain
`timescale 1ns/1ps
interface bcrd_fifo_if #(
    parameter int W     = 16,
    parameter int DEPTH = 16
);
    logic                       in_valid;
    logic                       in_ready;
    logic [W-1:0]               in_data;
    logic                       out_valid;
    logic                       out_ready;
    logic [W-1:0]               out_data;
    logic [$clog2(DEPTH+1)-1:0] count;

    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, count);
    modport user  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, count);
endinterface

/* design/bcrd_fifo.sv */
// Result FIFO with parameter width and depth and an occupancy count
`timescale 1ns/1ps
module bcrd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic   i_clk,
    input  wire logic   i_nrst,
    input  wire logic   i_ce,
    bcrd_fifo_if.store  fif
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [CW-1:0] count_ff;
    logic          push;
    logic          pop;

    assign fif.in_ready  = (count_ff != CW'(DEPTH));
    assign fif.out_valid = (count_ff != '0);
    // Head word is held in the array flops; the top registers it onto the bus
    assign fif.out_data  = mem[rptr_ff];
    assign fif.count     = count_ff;
    assign push = i_ce && fif.in_valid && fif.in_ready;
    assign pop  = i_ce && fif.out_ready && fif.out_valid;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr_ff] <= fif.in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end
endmodule

/* design/bcrd_top.sv */
// Block-transfer command register, raster-op datapath, source address split and read-fetch throttle
`timescale 1ns/1ps
module bcrd_top #(
    parameter int FIFO_DEPTH  = bcrd_pkg::FIFO_DEPTH,
    parameter int FIFO_RESUME = bcrd_pkg::FIFO_RESUME
) (
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_CE,
    input  wire logic [16:0] I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    input  wire logic [15:0] I_SRC_PIX,
    input  wire logic [15:0] I_DST_PIX,
    input  wire logic [15:0] I_PAT_PIX,
    input  wire logic        I_PIX_VALID,
    output logic      [15:0] O_RES_PIX,
    output logic             O_RES_VALID,
    input  wire logic [15:0] I_MEM_DATA,
    input  wire logic        I_MEM_VALID,
    output logic             O_FETCH_EN,
    input  wire logic        I_OP_DONE,
    output logic             O_START,
    output logic             O_BUSY,
    output logic      [3:0]  O_OP_CODE,
    output logic             O_OP_RESERVED,
    output logic             O_COLOR16,
    output logic      [2:0]  O_CE_START_BIT,
    output logic      [20:0] O_SRC_ADDR,
    output logic             O_HOST_ALIGN,
    output logic      [14:0] O_PAT_BASE,
    output logic      [2:0]  O_PAT_LINE,
    output logic      [3:0]  O_PAT_PIX
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    // Bit i of the result is code bit {a[i], d[i]}; a is source or pattern
    function automatic logic [15:0] rop_apply(input logic [3:0] code, input logic [15:0] a,
                                              input logic [15:0] d, input logic wide);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = code[{a[i], d[i]}];
        end
        return wide ? r : {8'h00, r[7:0]};
    endfunction

    function automatic logic is_pattern(input logic [3:0] op);
        return (op == bcrd_pkg::OPC_PAT_ROP) || (op == bcrd_pkg::OPC_PAT_TRANS);
    endfunction

    logic [31:0]              cmd_ff;
    logic [20:0]              src_ff;
    logic                     fmt16_ff;
    logic                     busy_ff;
    logic                     start_ff;
    logic [31:0]              rdata_ff;
    logic [15:0]              res_ff;
    logic                     res_vld_ff;
    logic                     fetch_en_ff;
    bcrd_pkg::bcrd_fetch_e    st_ff;
    bcrd_pkg::bcrd_fetch_e    nxt_st;
    logic [3:0]               op_ff;
    logic                     opres_ff;
    logic [2:0]               cestart_ff;
    logic [20:0]              srcaddr_ff;
    logic                     align_ff;
    logic [14:0]              pbase_ff;
    logic [2:0]               pline_ff;
    logic [3:0]               ppix_ff;

    logic                     wr_ctrl;
    logic                     wr_cmd;
    logic                     wr_src;
    logic                     rd_data;
    logic                     is_read;
    logic [3:0]               rop_code;
    logic [3:0]               op_sel;
    logic [CW-1:0]            fcount;

    bcrd_fifo_if #(.W(16), .DEPTH(FIFO_DEPTH)) fif ();

    bcrd_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .i_ce   (I_CE),
        .fif    (fif)
    );

    assign rop_code = cmd_ff[bcrd_pkg::CMD_ROP_LSB +: 4];
    assign op_sel   = cmd_ff[bcrd_pkg::CMD_OP_LSB +: 4];
    assign is_read  = (op_sel == bcrd_pkg::OPC_READ);
    assign fcount   = fif.count;
    assign wr_ctrl  = I_CE && I_WR && (I_ADDR == bcrd_pkg::OFF_CTRL);
    assign wr_cmd   = I_CE && I_WR && (I_ADDR == bcrd_pkg::OFF_CMD);
    assign wr_src   = I_CE && I_WR && (I_ADDR == bcrd_pkg::OFF_SRC);
    assign rd_data  = I_CE && I_RD && (I_ADDR == bcrd_pkg::OFF_DATA);

    // Memory words enter only while fetch is granted; in_ready still guards the lag cycle
    assign fif.in_valid  = I_MEM_VALID && fetch_en_ff && busy_ff && is_read;
    assign fif.in_data   = I_MEM_DATA;
    assign fif.out_ready = rd_data;

    // Register writes
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmd_ff   <= bcrd_pkg::CMD_RST;
            src_ff   <= bcrd_pkg::SRC_RST[20:0];
            fmt16_ff <= 1'b0;
        end else begin
            if (wr_cmd) begin
                cmd_ff <= {12'h000, I_WDATA[bcrd_pkg::CMD_ROP_LSB +: 4], 12'h000,
                           I_WDATA[bcrd_pkg::CMD_OP_LSB +: 4]};
            end
            if (wr_src) begin
                src_ff <= I_WDATA[bcrd_pkg::SRC_W-1:0];
            end
            if (wr_ctrl) begin
                fmt16_ff <= I_WDATA[bcrd_pkg::CTRL_FMT_BIT];
            end
        end
    end

    // Busy is ended by the engine; a zero written to enable mid-operation has no effect
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            busy_ff  <= 1'b0;
            start_ff <= 1'b0;
        end else if (I_CE) begin
            start_ff <= wr_ctrl && I_WDATA[bcrd_pkg::CTRL_EN_BIT] && !busy_ff;
            if (wr_ctrl && I_WDATA[bcrd_pkg::CTRL_EN_BIT] && !busy_ff) begin
                busy_ff <= 1'b1;
            end else if (I_OP_DONE) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Read-transfer throttle: no refill target, only a full stop and a resume level
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            bcrd_pkg::ST_IDLE: begin
                // A read started on a FIFO left full must not fetch until it drains below the resume level
                if (busy_ff && is_read && fcount == CW'(FIFO_DEPTH)) begin
                    nxt_st = bcrd_pkg::ST_PAUSE;
                end else if (busy_ff && is_read) begin
                    nxt_st = bcrd_pkg::ST_RUN;
                end
            end
            bcrd_pkg::ST_RUN: begin
                if (!busy_ff || I_OP_DONE) begin
                    nxt_st = bcrd_pkg::ST_IDLE;
                end else if (fcount == CW'(FIFO_DEPTH)) begin
                    nxt_st = bcrd_pkg::ST_PAUSE;
                end
            end
            bcrd_pkg::ST_PAUSE: begin
                if (!busy_ff || I_OP_DONE) begin
                    nxt_st = bcrd_pkg::ST_IDLE;
                end else if (fcount < CW'(FIFO_RESUME)) begin
                    nxt_st = bcrd_pkg::ST_RUN;
                end
            end
            default: begin
                nxt_st = bcrd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_ff       <= bcrd_pkg::ST_IDLE;
            fetch_en_ff <= 1'b0;
        end else if (I_CE) begin
            st_ff       <= nxt_st;
            fetch_en_ff <= (nxt_st == bcrd_pkg::ST_RUN);
        end
    end

    // Pixel datapath, one cycle of latency
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            res_ff     <= '0;
            res_vld_ff <= 1'b0;
        end else if (I_CE) begin
            res_vld_ff <= I_PIX_VALID;
            if (I_PIX_VALID) begin
                res_ff <= rop_apply(rop_code, is_pattern(op_sel) ? I_PAT_PIX : I_SRC_PIX,
                                    I_DST_PIX, fmt16_ff);
            end
        end
    end

    // Decoded command and source address views
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            op_ff      <= '0;
            opres_ff   <= 1'b0;
            cestart_ff <= '0;
            srcaddr_ff <= '0;
            align_ff   <= 1'b0;
            pbase_ff   <= '0;
            pline_ff   <= '0;
            ppix_ff    <= '0;
        end else if (I_CE) begin
            op_ff      <= op_sel;
            opres_ff   <= (op_sel > bcrd_pkg::OPC_SOLID);
            cestart_ff <= rop_code[2:0];
            srcaddr_ff <= src_ff;
            align_ff   <= src_ff[0];
            if (fmt16_ff) begin
                pbase_ff <= {1'b0, src_ff[20:bcrd_pkg::P16_BASE_LSB]};
                pline_ff <= src_ff[bcrd_pkg::P16_LINE_LSB +: 3];
                ppix_ff  <= src_ff[3:0];
            end else begin
                pbase_ff <= src_ff[20:bcrd_pkg::P8_BASE_LSB];
                pline_ff <= src_ff[bcrd_pkg::P8_LINE_LSB +: 3];
                ppix_ff  <= {1'b0, src_ff[2:0]};
            end
        end
    end

    // Read port; unmapped addresses and an empty data port answer zero
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rdata_ff <= '0;
        end else if (I_CE && I_RD) begin
            if (I_ADDR == bcrd_pkg::OFF_CTRL) begin
                rdata_ff <= 32'(fmt16_ff) << bcrd_pkg::CTRL_FMT_BIT;
            end else if (I_ADDR == bcrd_pkg::OFF_STAT) begin
                rdata_ff <= (32'(busy_ff) << bcrd_pkg::STAT_BUSY)
                          | (32'(fcount == CW'(FIFO_DEPTH)) << bcrd_pkg::STAT_FULL)
                          | (32'(fcount >= CW'(FIFO_DEPTH/2)) << bcrd_pkg::STAT_HALF)
                          | (32'(fcount != '0) << bcrd_pkg::STAT_NEMPTY)
                          | (32'(5'(FIFO_DEPTH - int'(fcount))) << bcrd_pkg::STAT_FREE_LSB)
                          | (32'(5'(fcount)) << bcrd_pkg::STAT_USED_LSB);
            end else if (I_ADDR == bcrd_pkg::OFF_CMD) begin
                rdata_ff <= cmd_ff;
            end else if (I_ADDR == bcrd_pkg::OFF_SRC) begin
                rdata_ff <= {11'h000, src_ff};
            end else if (I_ADDR == bcrd_pkg::OFF_DATA) begin
                rdata_ff <= fif.out_valid ? {16'h0000, fif.out_data} : 32'h00000000;
            end else begin
                rdata_ff <= 32'h00000000;
            end
        end
    end

    assign O_RDATA        = rdata_ff;
    assign O_RES_PIX      = res_ff;
    assign O_RES_VALID    = res_vld_ff;
    assign O_FETCH_EN     = fetch_en_ff;
    assign O_START        = start_ff;
    assign O_BUSY         = busy_ff;
    assign O_OP_CODE      = op_ff;
    assign O_OP_RESERVED  = opres_ff;
    assign O_COLOR16      = fmt16_ff;
    assign O_CE_START_BIT = cestart_ff;
    assign O_SRC_ADDR     = srcaddr_ff;
    assign O_HOST_ALIGN   = align_ff;
    assign O_PAT_BASE     = pbase_ff;
    assign O_PAT_LINE     = pline_ff;
    assign O_PAT_PIX      = ppix_ff;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    a_fetch_halt_full: assert property ((I_CE && busy_ff && is_read && !I_OP_DONE
        && fcount == CW'(FIFO_DEPTH)) |=> !O_FETCH_EN) else $error("fetch not halted on full FIFO");
    a_fetch_resume_low: assert property ((I_CE && st_ff == bcrd_pkg::ST_PAUSE && busy_ff
        && !I_OP_DONE && fcount < CW'(FIFO_RESUME)) |=> O_FETCH_EN) else $error("fetch not resumed");
    a_pause_holds_high: assert property ((I_CE && st_ff == bcrd_pkg::ST_PAUSE
        && fcount >= CW'(FIFO_RESUME)) |=> !O_FETCH_EN) else $error("fetch resumed too early");
    a_rop_xor_path: assert property ((I_CE && I_PIX_VALID && fmt16_ff && rop_code == 4'h6
        && !is_pattern(op_sel)) |=> O_RES_PIX == $past(I_SRC_PIX ^ I_DST_PIX)) else $error("xor result wrong");
    a_pattern_copy: assert property ((I_CE && I_PIX_VALID && fmt16_ff && rop_code == 4'hC
        && is_pattern(op_sel)) |=> O_RES_PIX == $past(I_PAT_PIX)) else $error("pattern copy wrong");
    a_narrow_pixel: assert property ((I_CE && I_PIX_VALID && !fmt16_ff)
        |=> O_RES_PIX[15:8] == 8'h00) else $error("8 bpp result has high byte");
    a_ce_start_bit: assert property (I_CE |=> O_CE_START_BIT == $past(cmd_ff[18:16]))
        else $error("expansion start bit wrong");
    a_pat_split16: assert property ((I_CE && fmt16_ff) |=> (O_PAT_PIX == $past(src_ff[3:0])
        && O_PAT_LINE == $past(src_ff[6:4]))) else $error("16 bpp pattern split wrong");
    a_pat_split8: assert property ((I_CE && !fmt16_ff) |=> (O_PAT_BASE == $past(src_ff[20:6])
        && O_PAT_PIX[3] == 1'b0)) else $error("8 bpp pattern split wrong");
    a_cmd_unused_zero: assert property ((I_CE && I_RD && I_ADDR == bcrd_pkg::OFF_CMD)
        |=> (O_RDATA[31:20] == 12'h000 && O_RDATA[15:4] == 12'h000)) else $error("unused command bits set");
    a_enable_clear_ign: assert property ((I_CE && busy_ff && !I_OP_DONE) |=> O_BUSY)
        else $error("busy dropped without completion");
    a_reserved_flag: assert property (I_CE |=> O_OP_RESERVED == ($past(op_sel) > 4'hC))
        else $error("reserved decode wrong");

    c_pause_resume: cover property (st_ff == bcrd_pkg::ST_PAUSE ##[1:200] st_ff == bcrd_pkg::ST_RUN);
    c_start_read: cover property (O_START && is_read);
    c_pattern_pixel: cover property (O_RES_VALID && is_pattern(op_sel));
endmodule

/* tb/bcrd_mem_model.sv */
// Display-memory model that streams words while fetching is allowed
`timescale 1ns/1ps
module bcrd_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_fetch_en,
    input  wire logic        i_slow,
    output logic             o_valid,
    output logic      [15:0] o_data
);
    logic [15:0] word_ff;
    logic        gap_ff;

    // Slow mode leaves a hole every other cycle; an idle data bus toggles so stale words never look valid
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            word_ff <= 16'h1000;
            gap_ff  <= 1'b0;
            o_valid <= 1'b0;
            o_data  <= 16'hFFFF;
        end else begin
            gap_ff  <= i_slow & ~gap_ff;
            o_valid <= i_fetch_en & ~gap_ff;
            if (i_fetch_en & ~gap_ff) begin
                o_data  <= word_ff;
                word_ff <= word_ff + 16'h0001;
            end else begin
                o_data <= ~o_data;
            end
        end
    end
endmodule

/* tb/tb_bcrd_top.sv */
// Self-checking testbench of the command, raster-op and read-fetch block
`timescale 1ns/1ps
module tb_bcrd_top;
    logic        I_CLK, I_NRST, I_CE, I_WR, I_RD, I_PIX_VALID, I_OP_DONE, slow, mem_valid;
    logic [16:0] I_ADDR;
    logic [31:0] I_WDATA, rd, O_RDATA;
    logic [15:0] I_SRC_PIX, I_DST_PIX, I_PAT_PIX, mem_data, O_RES_PIX;
    logic        O_RES_VALID, O_FETCH_EN, O_START, O_BUSY, O_OP_RESERVED, O_COLOR16, O_HOST_ALIGN;
    logic [3:0]  O_OP_CODE, O_PAT_PIX;
    logic [2:0]  O_CE_START_BIT, O_PAT_LINE;
    logic [20:0] O_SRC_ADDR;
    logic [14:0] O_PAT_BASE;
    int          errors, n_tests, k;

    bcrd_top i_dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SRC_PIX(I_SRC_PIX), .I_DST_PIX(I_DST_PIX),
        .I_PAT_PIX(I_PAT_PIX), .I_PIX_VALID(I_PIX_VALID), .O_RES_PIX(O_RES_PIX), .O_RES_VALID(O_RES_VALID),
        .I_MEM_DATA(mem_data), .I_MEM_VALID(mem_valid), .O_FETCH_EN(O_FETCH_EN), .I_OP_DONE(I_OP_DONE),
        .O_START(O_START), .O_BUSY(O_BUSY), .O_OP_CODE(O_OP_CODE), .O_OP_RESERVED(O_OP_RESERVED),
        .O_COLOR16(O_COLOR16), .O_CE_START_BIT(O_CE_START_BIT), .O_SRC_ADDR(O_SRC_ADDR),
        .O_HOST_ALIGN(O_HOST_ALIGN), .O_PAT_BASE(O_PAT_BASE), .O_PAT_LINE(O_PAT_LINE), .O_PAT_PIX(O_PAT_PIX));

    bcrd_mem_model i_mem (.i_clk(I_CLK), .i_nrst(I_NRST), .i_fetch_en(O_FETCH_EN), .i_slow(slow),
        .o_valid(mem_valid), .o_data(mem_data));

    task automatic stop_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [16:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
        #1;
    endtask

    task automatic rdr(input logic [16:0] a);
        @(posedge I_CLK);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        rd = O_RDATA;
    endtask

    task automatic settle();
        @(posedge I_CLK);
        #1;
    endtask

    function automatic logic [15:0] rop_f(input logic [3:0] r, input logic [15:0] a, input logic [15:0] d,
                                          input logic w);
        logic [15:0] y;
        for (int i = 0; i < 16; i++)
            y[i] = r[{a[i], d[i]}];
        if (!w)
            y[15:8] = 8'h00;
        return y;
    endfunction

    task automatic t_reset();
        rdr(bcrd_pkg::OFF_CMD);
        chk(rd, 32'h00000000, "cmd reset");
        rdr(bcrd_pkg::OFF_SRC);
        chk(rd, 32'h00000000, "src reset");
        rdr(17'h00010);
        chk(rd, 32'h00000000, "unmapped read");
        rdr(bcrd_pkg::OFF_DATA);
        chk(rd, 32'h00000000, "empty fifo read");
    endtask

    task automatic t_cmd();
        wr(bcrd_pkg::OFF_CMD, 32'hFFFFFFFF);
        rdr(bcrd_pkg::OFF_CMD);
        chk(rd, 32'h000F000F, "cmd unused bits");
        for (int i = 0; i < 16; i++) begin
            wr(bcrd_pkg::OFF_CMD, {12'h000, 4'(i), 12'h000, 4'(i)});
            settle();
            chk({28'h0, O_OP_CODE}, 32'(i), "op code");
            chk({31'h0, O_OP_RESERVED}, {31'h0, i > 12}, "reserved op");
            chk({29'h0, O_CE_START_BIT}, 32'(i % 8), "expansion start bit");
        end
    endtask

    // Clock enable low must swallow a register write
    task automatic t_hold();
        @(posedge I_CLK);
        I_CE <= 1'b0;
        wr(bcrd_pkg::OFF_CMD, 32'h00050003);
        @(posedge I_CLK);
        I_CE <= 1'b1;
        rdr(bcrd_pkg::OFF_CMD);
        chk(rd, 32'h000F000F, "write ignored while frozen");
        chk({28'h0, O_OP_CODE}, 32'hF, "op code while frozen");
    endtask

    task automatic t_src(input logic [20:0] s);
        wr(bcrd_pkg::OFF_SRC, 32'hFFFFFFFF);
        rdr(bcrd_pkg::OFF_SRC);
        chk(rd, 32'h001FFFFF, "src width");
        wr(bcrd_pkg::OFF_CTRL, 32'h00000000);
        wr(bcrd_pkg::OFF_SRC, {11'h000, s});
        settle();
        chk({31'h0, O_COLOR16}, 32'h0, "8 bpp format");
        chk({11'h0, O_SRC_ADDR}, {11'h0, s}, "src addr");
        chk({31'h0, O_HOST_ALIGN}, {31'h0, s[0]}, "host align");
        chk({O_PAT_BASE, O_PAT_LINE, O_PAT_PIX}, {s[20:6], s[5:3], 1'b0, s[2:0]}, "8 bpp split");
        wr(bcrd_pkg::OFF_CTRL, 32'h00040000);
        settle();
        chk({31'h0, O_COLOR16}, 32'h1, "color format");
        chk({O_PAT_BASE, O_PAT_LINE, O_PAT_PIX}, {1'b0, s[20:7], s[6:4], s[3:0]}, "16 bpp split");
    endtask

    task automatic t_rop(input logic [3:0] op, input logic w);
        wr(bcrd_pkg::OFF_CTRL, {13'h0, w, 18'h0});
        for (int r = 0; r < 16; r++) begin
            wr(bcrd_pkg::OFF_CMD, {12'h000, 4'(r), 12'h000, op});
            @(posedge I_CLK);
            @(posedge I_CLK);
            I_PIX_VALID <= 1'b1;
            @(posedge I_CLK);
            I_PIX_VALID <= 1'b0;
            #1;
            chk({31'h0, O_RES_VALID}, 32'h1, "result valid");
            chk({16'h0, O_RES_PIX}, {16'h0, rop_f(4'(r), (op == 4'h6) ? I_PAT_PIX : I_SRC_PIX, I_DST_PIX, w)},
                "rop result");
        end
    endtask

    task automatic t_fetch();
        wr(bcrd_pkg::OFF_CMD, {28'h0, bcrd_pkg::OPC_READ});
        wr(bcrd_pkg::OFF_CTRL, 32'h00000001);
        chk({30'h0, O_START, O_BUSY}, 32'h3, "start pulse");
        wr(bcrd_pkg::OFF_CTRL, 32'h00000001);
        chk({31'h0, O_START}, 32'h0, "start while busy");
        for (k = 0; k < 20 && O_FETCH_EN !== 1'b1; k++)
            settle();
        chk({31'h0, O_FETCH_EN}, 32'h1, "fetch granted");
        for (k = 0; k < 200 && O_FETCH_EN !== 1'b0; k++)
            settle();
        repeat (4) settle();
        chk({31'h0, O_FETCH_EN}, 32'h0, "halt on full");
        rdr(bcrd_pkg::OFF_STAT);
        chk(rd, 32'h10000071, "full status");
        rdr(bcrd_pkg::OFF_DATA);
        chk(rd, 32'h00001000, "first word");
        rdr(bcrd_pkg::OFF_DATA);
        chk(rd, 32'h00001001, "second word");
        repeat (4) settle();
        chk({31'h0, O_FETCH_EN}, 32'h0, "no refill at 14");
        rdr(bcrd_pkg::OFF_DATA);
        repeat (3) settle();
        chk({31'h0, O_FETCH_EN}, 32'h1, "resume below 14");
        @(posedge I_CLK);
        I_OP_DONE <= 1'b1;
        @(posedge I_CLK);
        I_OP_DONE <= 1'b0;
        settle();
        chk({31'h0, O_BUSY}, 32'h0, "busy ends");
    endtask

    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end

    // Whole run is some 400 cycles; fifty times that means a hang
    initial begin
        #100us;
        errors++;
        stop_test();
    end

    initial begin
        {I_NRST, I_WR, I_RD, I_PIX_VALID, I_OP_DONE, slow} = 6'b000000;
        I_CE        = 1'b1;
        I_ADDR      = 17'h00000;
        I_WDATA     = 32'h00000000;
        I_SRC_PIX   = 16'hA5C3;
        I_DST_PIX   = 16'h6F09;
        I_PAT_PIX   = 16'h3C96;
        errors      = 0;
        n_tests     = 0;
        repeat (3) @(posedge I_CLK);
        I_NRST <= 1'b1;
        t_reset();
        t_cmd();
        t_hold();
        t_src(21'h1ABCDF);
        t_src(21'h054320);
        t_rop(bcrd_pkg::OPC_WRITE_ROP, 1'b1);
        t_rop(bcrd_pkg::OPC_PAT_ROP, 1'b0);
        t_rop(bcrd_pkg::OPC_PAT_ROP, 1'b1);
        slow <= 1'b1;
        t_fetch();
        stop_test();
    end
endmodule
